// file: core/touch_detect_output_logic.sv
/*
 * post-acquisition detection, integrators, max-on timer and output pin
 * driver of a single-channel capacitance sensor, with a classic
 * wishbone register slave.
 * assumes the acquisition logic gives a one-cycle burst_done_i with a
 * signed deviation on delta_i, asks for a burst with burst_req_i and
 * starts it on burst_go_o; the pin wire is resolved outside.
 */
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "touch_detect_regs.svh"

module touch_detect_output_logic #(
  parameter int DELTA_W = 16,
  parameter int HP_CYC  = `HEALTH_PULSE_CYC
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic [5:0]         adr_i,
  input  wire logic [31:0]        dat_i,
  output logic      [31:0]        dat_o,
  input  wire logic [3:0]         sel_i,
  input  wire logic               we_i,
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  output logic                    ack_o,
  input  wire logic               burst_done_i,
  input  wire logic signed [DELTA_W-1:0] delta_i,
  input  wire logic               burst_req_i,
  output logic                    burst_go_o,
  output logic                    fast_rate_o,
  output logic                    recal_o,
  input  wire logic               cal_clear_n_i,
  output logic                    out_o,
  output logic                    out_oe_o
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [`CTRL_WIDTH-1:0] ctrl_r;
  logic [7:0]             detect_level_r;
  logic [7:0]             release_margin_r;
  logic [8:0]             assert_target_r;
  logic [8:0]             release_target_r;
  logic [7:0]             max_on_count_r;
  logic [7:0]             sleep_cycles_r;
  logic [8:0]             assert_cnt_r;
  logic [8:0]             release_cnt_r;
  logic [16:0]            max_on_cnt_r;
  logic                   det_active_r;
  logic                   out_state_r;
  logic                   clr_pend_r;
  logic [2:0]             clr_sync_r;
  logic                   clr_stable_r;
  logic [7:0]             hp_cnt_r;
  touch_detect_pkg::health_state_e hp_state_r;

  logic        wb_hit;
  logic [3:0]  wb_idx;
  logic [31:0] rd_val;
  logic        latch_on;
  logic        cfg_conflict;
  logic signed [DELTA_W:0] dev;
  logic signed [DELTA_W:0] rel_level;
  logic        meets;
  logic        beyond;
  logic [8:0]  assert_inc;
  logic [8:0]  release_inc;
  logic        confirm;
  logic        release_done;
  logic [16:0] max_on_limit;
  logic        timeout;
  logic        ext_recal;
  logic        latch_clear;
  logic        health_on;
  logic [31:0] wr_merged;
  logic        hp_float;

  assign wb_hit = cyc_i && stb_i && !ack_o;
  assign wb_idx = adr_i[5:2];

  // latch mode is refused with stored-reference or learn modes
  assign cfg_conflict = ctrl_r[`CTRL_LATCH_EN] &&
                        (ctrl_r[`CTRL_STORED_REF] || ctrl_r[`CTRL_LEARN_EX]);
  assign latch_on = ctrl_r[`CTRL_LATCH_EN] && !cfg_conflict;

  // sense-adjusted deviation against detect level and release level
  assign dev = ctrl_r[`CTRL_SENSE_NEG] ? -{delta_i[DELTA_W-1], delta_i}
                                       : {delta_i[DELTA_W-1], delta_i};
  assign meets = dev >= $signed({{(DELTA_W-8){1'b0}}, 1'b0, detect_level_r});
  assign rel_level = $signed({{(DELTA_W-8){1'b0}}, 1'b0, detect_level_r}) -
                     $signed({{(DELTA_W-8){1'b0}}, 1'b0, release_margin_r});
  assign beyond = dev < rel_level;

  assign assert_inc   = assert_cnt_r + 9'h001;
  assign release_inc  = release_cnt_r + 9'h001;
  // a recalibration in the same burst wins over a new detection
  assign confirm      = burst_done_i && !det_active_r && meets && !ext_recal &&
                        (assert_inc >= assert_target_r);
  assign release_done = burst_done_i && det_active_r && beyond &&
                        (release_inc >= release_target_r);

  assign max_on_limit = (sleep_cycles_r == 8'h00) ?
                        ({9'h000, max_on_count_r} + 17'h00001) << `MAX_ON_SHIFT_AWAKE :
                        ({9'h000, max_on_count_r} + 17'h00001) << `MAX_ON_SHIFT_SLEEP;
  assign timeout = burst_done_i && det_active_r && !release_done &&
                   (max_on_count_r != `MAX_ON_DISABLE) &&
                   (max_on_cnt_r + 17'h00001 >= max_on_limit);

  // clear pin: low sampled at a burst clears a latched output, otherwise recalibrate once it is high again
  assign latch_clear = burst_done_i && latch_on && !clr_stable_r;
  assign ext_recal   = burst_done_i && !latch_on && clr_pend_r && clr_stable_r;

  assign health_on = !(ctrl_r[`CTRL_HEALTH_DIS] && sleep_cycles_r == 8'h00);

  // write data merged into the addressed word by byte lane
  assign wr_merged = merge(rd_val, dat_i, sel_i);

  // pin floats from the accepted request until the last float cycle
  assign hp_float = (hp_state_r == touch_detect_pkg::HP_IDLE && burst_req_i && health_on) ||
                    (hp_state_r == touch_detect_pkg::HP_FLOAT && hp_cnt_r != 8'h00);

  // register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r           <= `RST_CTRL;
      detect_level_r   <= `RST_DETECT_LEVEL;
      release_margin_r <= `RST_RELEASE_MARGIN;
      assert_target_r  <= `RST_ASSERT_TARGET;
      release_target_r <= `RST_RELEASE_TARGET;
      max_on_count_r   <= `RST_MAX_ON_COUNT;
      sleep_cycles_r   <= `RST_SLEEP_CYCLES;
    end else if (wb_hit && we_i) begin
      case (wb_idx)
        `ADR_CTRL: begin
          ctrl_r <= wr_merged[`CTRL_WIDTH-1:0];
        end
        `ADR_LEVELS: begin
          detect_level_r   <= wr_merged[7:0];
          release_margin_r <= wr_merged[15:8];
        end
        `ADR_INTEG: begin
          assert_target_r  <= wr_merged[8:0];
          release_target_r <= wr_merged[24:16];
        end
        `ADR_TIMING: begin
          max_on_count_r <= wr_merged[7:0];
          sleep_cycles_r <= wr_merged[15:8];
        end
        default: begin
        end
      endcase
    end
  end

  // read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    case (wb_idx)
      `ADR_CTRL:   rd_val = {23'h0, ctrl_r};
      `ADR_LEVELS: rd_val = {16'h0, release_margin_r, detect_level_r};
      `ADR_INTEG:  rd_val = {7'h0, release_target_r, 7'h0, assert_target_r};
      `ADR_TIMING: rd_val = {16'h0, sleep_cycles_r, max_on_count_r};
      `ADR_STATUS: begin
        rd_val[8:0] = assert_cnt_r;
        rd_val[`STAT_REL_LSB +: 9] = release_cnt_r;
        rd_val[`STAT_DET_ACTIVE] = det_active_r;
        rd_val[`STAT_OUT_STATE] = out_state_r;
        rd_val[`STAT_CFG_CONFLICT] = cfg_conflict;
      end
      `ADR_MAXON:  rd_val = {15'h0, max_on_cnt_r};
      default:     rd_val = 32'h0000_0000;
    endcase
  end

  // bus answer one cycle after the strobe, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= wb_hit;
      dat_o <= (wb_hit && !we_i) ? rd_val : 32'h0000_0000;
    end
  end

  // clear pin synchroniser; stable once second and third stages agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_sync_r   <= 3'h7;
      clr_stable_r <= 1'b1;
    end else begin
      clr_sync_r <= {clr_sync_r[1:0], cal_clear_n_i};
      if (clr_sync_r[1] == clr_sync_r[2]) begin
        clr_stable_r <= clr_sync_r[2];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_pend_r <= 1'b0;
    end else if (burst_done_i) begin
      clr_pend_r <= !latch_on && !clr_stable_r;
    end
  end

  // integrators and detection state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      assert_cnt_r  <= 9'h000;
      release_cnt_r <= 9'h000;
      det_active_r  <= 1'b0;
    end else if (timeout || ext_recal) begin
      assert_cnt_r  <= 9'h000;
      release_cnt_r <= 9'h000;
      det_active_r  <= 1'b0;
    end else if (burst_done_i) begin
      if (!det_active_r) begin
        release_cnt_r <= 9'h000;
        if (confirm) begin
          assert_cnt_r <= 9'h000;
          det_active_r <= 1'b1;
        end else if (meets) begin
          assert_cnt_r <= assert_inc;
        end else begin
          assert_cnt_r <= 9'h000;
        end
      end else begin
        if (release_done) begin
          release_cnt_r <= 9'h000;
          det_active_r  <= 1'b0;
        end else if (beyond) begin
          release_cnt_r <= release_inc;
        end else begin
          release_cnt_r <= 9'h000;
        end
      end
    end
  end

  // max-on timer restarts whenever the detection ends
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      max_on_cnt_r <= 17'h00000;
    end else if (timeout || ext_recal || !det_active_r) begin
      max_on_cnt_r <= 17'h00000;
    end else if (burst_done_i) begin
      max_on_cnt_r <= max_on_cnt_r + 17'h00001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      recal_o <= 1'b0;
    end else begin
      recal_o <= timeout || ext_recal;
    end
  end

  // logical output state per mode; a detection beats a same-burst clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_state_r <= 1'b0;
    end else if (ctrl_r[`CTRL_FLIP_EN]) begin
      if (confirm) begin
        out_state_r <= !out_state_r;
      end
    end else if (latch_on) begin
      if (confirm) begin
        out_state_r <= 1'b1;
      end else if (latch_clear) begin
        out_state_r <= 1'b0;
      end
    end else if (confirm) begin
      out_state_r <= 1'b1;
    end else if (release_done || timeout || ext_recal) begin
      out_state_r <= 1'b0;
    end
  end

  // fast burst rate while an enabled integrator is pending
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_rate_o <= 1'b0;
    end else begin
      fast_rate_o <= (ctrl_r[`CTRL_FAST_ASSERT] && !det_active_r &&
                      assert_cnt_r != 9'h000) ||
                     (ctrl_r[`CTRL_FAST_RELEASE] && det_active_r &&
                      release_cnt_r != 9'h000);
    end
  end

  // health pulse: float the pin before each burst starts, unless health is disabled with zero sleep cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hp_state_r <= touch_detect_pkg::HP_IDLE;
      hp_cnt_r   <= 8'h00;
      burst_go_o <= 1'b0;
    end else begin
      burst_go_o <= 1'b0;
      case (hp_state_r)
        touch_detect_pkg::HP_IDLE: begin
          if (burst_req_i && health_on) begin
            hp_state_r <= touch_detect_pkg::HP_FLOAT;
            hp_cnt_r   <= 8'(HP_CYC - 1);
          end else if (burst_req_i) begin
            burst_go_o <= 1'b1;
          end
        end
        touch_detect_pkg::HP_FLOAT: begin
          if (hp_cnt_r == 8'h00) begin
            hp_state_r <= touch_detect_pkg::HP_IDLE;
            burst_go_o <= 1'b1;
          end else begin
            hp_cnt_r <= hp_cnt_r - 8'h01;
          end
        end
        default: begin
          hp_state_r <= touch_detect_pkg::HP_IDLE;
        end
      endcase
    end
  end

  // pin level and enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_o    <= 1'b1;
      out_oe_o <= 1'b1;
    end else begin
      out_o    <= ctrl_r[`CTRL_POL_HIGH] ? out_state_r : !out_state_r;
      out_oe_o <= !hp_float;
    end
  end

endmodule // touch_detect_output_logic

// file: pkg/touch_detect_pkg.sv
/*
 * types of the touch detect output logic
 * assumes the constants of touch_detect_regs.svh alongside
 */
package touch_detect_pkg;

  typedef enum logic [1:0] {
    HP_IDLE  = 2'b01,
    HP_FLOAT = 2'b10
  } health_state_e;

endpackage

// file: pkg/touch_detect_regs.svh
/*
 * register offsets, field positions, reset values and timing counts of
 * the touch detect output logic; included by bare name
 */
`ifndef TOUCH_DETECT_REGS_SVH
`define TOUCH_DETECT_REGS_SVH

`define ADR_CTRL           4'h0
`define ADR_LEVELS         4'h1
`define ADR_INTEG          4'h2
`define ADR_TIMING         4'h3
`define ADR_STATUS         4'h4
`define ADR_MAXON          4'h5

`define CTRL_POL_HIGH      0
`define CTRL_FLIP_EN       1
`define CTRL_LATCH_EN      2
`define CTRL_HEALTH_DIS    3
`define CTRL_FAST_ASSERT   4
`define CTRL_FAST_RELEASE  5
`define CTRL_SENSE_NEG     6
`define CTRL_STORED_REF    7
`define CTRL_LEARN_EX      8
`define CTRL_WIDTH         9

`define STAT_REL_LSB       16
`define STAT_DET_ACTIVE    28
`define STAT_OUT_STATE     29
`define STAT_CFG_CONFLICT  30

`define RST_CTRL           9'h000
`define RST_DETECT_LEVEL   8'h06
`define RST_RELEASE_MARGIN 8'h02
`define RST_ASSERT_TARGET  9'h00a
`define RST_RELEASE_TARGET 9'h00a
`define RST_MAX_ON_COUNT   8'h0e
`define RST_SLEEP_CYCLES   8'h01

`define MAX_ON_DISABLE     8'hff
`define MAX_ON_SHIFT_SLEEP 4
`define MAX_ON_SHIFT_AWAKE 8

`define CLK_PERIOD_NS      100
`define HEALTH_PULSE_NS    15000
`define HEALTH_PULSE_CYC   ((`HEALTH_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: sim/detect_props.sv
/* checker of pin, burst start and recalibration timing
   bound to touch_detect_output_logic by the bench top */
`timescale 1ns/1ps
module detect_props #(
  parameter int HP_CYC = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ack_o,
  input wire logic burst_done_i,
  input wire logic burst_req_i,
  input wire logic burst_go_o,
  input wire logic recal_o,
  input wire logic out_o,
  input wire logic out_oe_o
);
  logic [7:0] float_cnt_r;

  // length of the current float
  always_ff @(posedge clk_i) begin
    if (rst_i || out_oe_o) begin
      float_cnt_r <= 8'h00;
    end else begin
      float_cnt_r <= float_cnt_r + 8'h01;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_recal_pulse: assert property (recal_o |=> !recal_o)
    else $error("recal longer than one cycle");
  a_recal_cause: assert property (recal_o |-> $past(burst_done_i))
    else $error("recal without a burst");
  a_float_len: assert property ($rose(out_oe_o) |-> float_cnt_r == HP_CYC)
    else $error("float length wrong");
  a_go_with_oe: assert property ($rose(out_oe_o) |-> burst_go_o)
    else $error("burst not started at float end");
  a_go_pulse: assert property (burst_go_o |=> !burst_go_o)
    else $error("burst start longer than one cycle");
  a_go_cause: assert property (burst_go_o |-> $past(burst_req_i) || !$past(out_oe_o))
    else $error("burst start without request");
  a_no_go_float: assert property (!out_oe_o |-> !burst_go_o)
    else $error("burst started while floating");
  a_out_cause: assert property ($changed(out_o) |-> $past(burst_done_i, 2)
    || $past(ack_o) || $past(ack_o, 2) || $past(ack_o, 3))
    else $error("pin moved without burst or write");
endmodule // detect_props

// file: sim/host_model.sv
/* host controller: reads the pin through a pull-up, pulses clear
   assumes one clock shared with the sensor logic */
`timescale 1ns/1ps
module host_model #(
  parameter int HOLD = 30
) (
  input  wire logic clk_i,
  input  wire logic clear_go_i,
  input  wire logic out_o,
  input  wire logic out_oe_o,
  output logic      cal_clear_n_o,
  output logic      pin_o
);
  logic [7:0] hold_r = 8'h00;

  // clear held low for HOLD cycles, across one burst
  always @(posedge clk_i) begin
    if (clear_go_i) begin
      hold_r <= 8'(HOLD);
    end else if (hold_r != 8'h00) begin
      hold_r <= hold_r - 8'h01;
    end
  end
  assign cal_clear_n_o = (hold_r == 8'h00);
  // floating pin reads high
  assign pin_o = out_oe_o ? out_o : 1'b1;
endmodule // host_model

// file: sim/tb_top.sv
/* self-checking bench of touch_detect_output_logic
   drives bus and acquisition strobes, host model on the pin */
`timescale 1ns/1ps
`include "touch_detect_regs.svh"
module tb_top;
  localparam int HP = 4;
  logic               clk_i;
  logic               rst_i;
  logic [5:0]         adr_i;
  logic [31:0]        dat_i;
  logic [31:0]        dat_o;
  logic               we_i;
  logic               cyc_i;
  logic               stb_i;
  logic               ack_o;
  logic               done_i;
  logic signed [15:0] delta_i;
  logic               req_i;
  logic               go_o;
  logic               fast_o;
  logic               recal_o;
  logic               clr_n;
  logic               out_o;
  logic               oe_o;
  logic               pin;
  logic               clr_go;
  logic [31:0]        rd;
  int                 failures = 0;
  int                 cmp_count = 0;
  int                 recals = 0;
  int                 r0;

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (recal_o === 1'b1) recals <= recals + 1;

  touch_detect_output_logic #(.DELTA_W(16), .HP_CYC(HP)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .sel_i(4'hf), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .burst_done_i(done_i), .delta_i(delta_i), .burst_req_i(req_i), .burst_go_o(go_o),
    .fast_rate_o(fast_o), .recal_o(recal_o), .cal_clear_n_i(clr_n), .out_o(out_o),
    .out_oe_o(oe_o));
  host_model #(.HOLD(30)) host_u (.clk_i(clk_i), .clear_go_i(clr_go), .out_o(out_o),
    .out_oe_o(oe_o), .cal_clear_n_o(clr_n), .pin_o(pin));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [3:0] word, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {word, 2'b00};
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      failures++;
      finish_test();
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic bursts(input logic signed [15:0] d, input int n);
    repeat (n) begin
      @(posedge clk_i);
      done_i <= 1'b1;
      delta_i <= d;
      @(posedge clk_i);
      done_i <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask

  task automatic setup(input logic [8:0] ctrl, input logic [31:0] timing);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, `ADR_CTRL, {23'h0, ctrl});
    wb(1'b1, `ADR_INTEG, 32'h0002_0002);
    wb(1'b1, `ADR_TIMING, timing);
    r0 = recals;
  endtask

  // clear pin low over one burst, then high over the next
  task automatic clear_pin(input logic signed [15:0] d);
    @(posedge clk_i);
    clr_go <= 1'b1;
    @(posedge clk_i);
    clr_go <= 1'b0;
    repeat (8) @(posedge clk_i);
    bursts(d, 1);
    repeat (30) @(posedge clk_i);
    bursts(d, 1);
  endtask

  task automatic health(input logic [31:0] exp);
    int fl;
    int n;
    @(posedge clk_i);
    req_i <= 1'b1;
    @(posedge clk_i);
    req_i <= 1'b0;
    fl = 0;
    n = 0;
    while (go_o !== 1'b1 && n < 50) begin
      if (oe_o === 1'b0) fl++;
      n++;
      @(posedge clk_i);
    end
    check(32'(fl), exp);
    check(32'(n < 50), 32'h1);
  endtask

  task automatic t_reset_values();
    wb(1'b0, `ADR_CTRL, 32'h0);
    check(rd, 32'h0);
    check(32'(pin), 32'h1);
    wb(1'b0, `ADR_LEVELS, 32'h0);
    check(rd, 32'h0000_0206);
    wb(1'b0, `ADR_INTEG, 32'h0);
    check(rd, 32'h000a_000a);
    wb(1'b0, `ADR_TIMING, 32'h0);
    check(rd, 32'h0000_010e);
    wb(1'b1, 4'hf, 32'hffff_ffff);
    wb(1'b0, 4'hf, 32'h0);
    check(rd, 32'h0);
  endtask

  task automatic t_steady();
    setup(9'h000, 32'h0000_010e);
    bursts(6, 1);
    bursts(5, 1);
    bursts(6, 1);
    check(32'(pin), 32'h1);
    bursts(6, 1);
    check(32'(pin), 32'h0);
    bursts(4, 3);
    check(32'(pin), 32'h0);
    bursts(3, 1);
    check(32'(pin), 32'h0);
    bursts(3, 1);
    check(32'(pin), 32'h1);
    wb(1'b1, `ADR_LEVELS, 32'h0000_0006);
    bursts(6, 2);
    bursts(5, 2);
    check(32'(pin), 32'h1);
    setup(9'h040, 32'h0000_010e);
    bursts(-6, 2);
    check(32'(pin), 32'h0);
    bursts(-3, 2);
    check(32'(pin), 32'h1);
  endtask

  task automatic t_max_on();
    setup(9'h000, 32'h0000_0100);
    bursts(6, 17);
    check(32'(recals - r0), 32'h0);
    bursts(6, 1);
    check(32'(recals - r0), 32'h1);
    check(32'(pin), 32'h1);
    setup(9'h000, 32'h0000_0000);
    bursts(6, 257);
    check(32'(recals - r0), 32'h0);
    bursts(6, 1);
    check(32'(recals - r0), 32'h1);
    setup(9'h000, 32'h0000_01ff);
    bursts(6, 4100);
    check(32'(recals - r0), 32'h0);
    check(32'(pin), 32'h0);
  endtask

  task automatic t_modes();
    setup(9'h002, 32'h0000_010e);
    bursts(6, 2);
    check(32'(pin), 32'h0);
    bursts(0, 2);
    check(32'(pin), 32'h0);
    bursts(6, 2);
    check(32'(pin), 32'h1);
    bursts(0, 2);
    bursts(6, 2);
    clear_pin(6);
    check(32'(recals - r0), 32'h1);
    check(32'(pin), 32'h0);
    setup(9'h004, 32'h0000_0100);
    bursts(6, 2);
    bursts(0, 3);
    check(32'(pin), 32'h0);
    clear_pin(0);
    check(32'(pin), 32'h1);
    check(32'(recals - r0), 32'h0);
    bursts(6, 2);
    bursts(6, 15);
    check(32'(recals - r0), 32'h0);
    bursts(6, 1);
    check(32'(recals - r0), 32'h1);
    check(32'(pin), 32'h0);
    setup(9'h084, 32'h0000_010e);
    wb(1'b0, `ADR_STATUS, 32'h0);
    check(32'(rd[`STAT_CFG_CONFLICT]), 32'h1);
    bursts(6, 2);
    bursts(0, 2);
    check(32'(pin), 32'h1);
  endtask

  task automatic t_pol_fast_health();
    setup(9'h031, 32'h0000_010e);
    check(32'(pin), 32'h0);
    bursts(6, 1);
    check(32'(fast_o), 32'h1);
    bursts(6, 1);
    check(32'(fast_o), 32'h0);
    check(32'(pin), 32'h1);
    bursts(0, 1);
    check(32'(fast_o), 32'h1);
    bursts(0, 1);
    check(32'(fast_o), 32'h0);
    check(32'(pin), 32'h0);
    health(32'(HP));
    wb(1'b1, `ADR_CTRL, 32'h0000_0008);
    health(32'(HP));
    wb(1'b1, `ADR_TIMING, 32'h0000_000e);
    health(32'h0);
  endtask

  initial begin
    rst_i = 1'b1;
    adr_i = 6'h00;
    dat_i = 32'h0;
    we_i = 1'b0;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    done_i = 1'b0;
    delta_i = 16'sh0000;
    req_i = 1'b0;
    clr_go = 1'b0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_steady();
    t_max_on();
    t_modes();
    t_pol_fast_health();
    finish_test();
  end
endmodule // tb_top

bind touch_detect_output_logic detect_props #(.HP_CYC(HP_CYC)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .ack_o(ack_o), .burst_done_i(burst_done_i),
  .burst_req_i(burst_req_i), .burst_go_o(burst_go_o), .recal_o(recal_o),
  .out_o(out_o), .out_oe_o(out_oe_o));
